// >>> include/mts_regs.svh
`ifndef MTS_REGS_SVH
`define MTS_REGS_SVH

// apb register byte offsets
`define REG_CTRL 8'h00
`define REG_SRC_EN 8'h04
`define REG_STATUS 8'h08
`define REG_VEC_COUNT 8'h0C
`define CTRL_EN_BIT 0
`define CTRL_RESET 1'h0
`define SRC_EN_RESET 16'h0000

// control word area in internal ram
`define CW_BASE 16'hFE06
`define CW_LAST 16'hFE25
`define RAM_PAGE 8'hFE
`define SFR_PAGE 8'hFF

// operation codes in the low six mode bits
`define MODE_EVT 6'h01
`define MODE_BLK 6'h13
`define MODE_BLKP 6'h14
`define MODE_DIF 6'h19
`define MODE_DIFP 6'h1A
`define DIF_TOP 2'h2
`define MODE_SIZE_BIT 7
`define MODE_DIR_BIT 6

// channel layout, below the channel pointer
`define OFS_MSC 16'h0001
`define OFS_MPTR 16'h0003
`define OFS_PREV 16'h0003
`define OFS_PREV_P 16'h0005
`define BUF_OFS_BLK 16'h0001
`define BUF_OFS_DIF 16'h0003
`define BUF_OFS_DIFP 16'h0002

`endif

// >>> include/mts_pkg.sv
package mts_pkg;

   typedef struct packed {
      logic we;
      logic word;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_cmd_t;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0000,
      S_CW = 4'b0001,
      S_REGISTER_SOURCE_POINTER = 4'b0010,
      S_MSC = 4'b0011,
      S_MPTR = 4'b0100,
      S_PREV = 4'b0101,
      S_SRC = 4'b0110,
      S_DST = 4'b0111,
      S_PREVW = 4'b1000,
      S_MPTRW = 4'b1001,
      S_MSCW = 4'b1010,
      S_END = 4'b1011
   } state_t;

endpackage

// >>> rtl/mem_access_port.sv
`timescale 1ns/1ps
module mem_access_port (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic start,
   input mts_pkg::mem_cmd_t cmd,
   output mts_pkg::mem_cmd_t mem_cmd,
   output logic mem_req,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   output logic done,
   output logic [15:0] rdata
);
   import mts_pkg::*;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_req <= 1'b0;
         mem_cmd <= '0;
      end else if (start && !mem_req) begin
         mem_req <= 1'b1;
         mem_cmd <= cmd;
      end else if (mem_req && mem_ack) begin
         mem_req <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         done <= 1'b0;
         rdata <= 16'h0000;
      end else begin
         done <= mem_req && mem_ack;
         if (mem_req && mem_ack)
            rdata <= mem_cmd.word ? mem_rdata : {8'h00, mem_rdata[7:0]};
      end
   end
endmodule // mem_access_port

// >>> rtl/buffer_addr_calc.sv
`timescale 1ns/1ps
`include "mts_regs.svh"
module buffer_addr_calc (
   input wire logic [5:0] op,
   input wire logic word,
   input wire logic [15:0] ch_addr,
   input wire logic [7:0] service_counter,
   input wire logic [15:0] mptr,
   output logic [15:0] buf_addr
);
   logic [15:0] m1;
   logic [15:0] m2;

   always_comb begin
      m1 = {8'h00, service_counter};
      m2 = {7'h00, service_counter, 1'b0};
      unique case (op)
         `MODE_BLK: buf_addr = word ? ch_addr - m2 - `BUF_OFS_BLK
                                    : ch_addr - m1 - `BUF_OFS_BLK; // R4
         `MODE_DIF: buf_addr = ch_addr - m2 - `BUF_OFS_DIF; // R12
         `MODE_DIFP: buf_addr = mptr - m2 + `BUF_OFS_DIFP; // R13
         default: buf_addr = mptr; // R6
      endcase
   end
endmodule // buffer_addr_calc

// >>> rtl/transfer_service.sv
// Operation
// R1: event count mode steps counter per request; vector raised when it reaches 00H.
// R2: copy and delta modes fetch register source pointer at channel pointer.
// R3: size_direction_field picks byte or word, register-to-buffer or buffer-to-register.
// R4: channel block copy buffer is pointer minus counter (twice for words) minus 1.
// R5: channel block copy decrements counter; zero raises vector.
// R6: pointer block copy uses memory_pointer, then adds one or two.
// R7: pointer block copy decrements counter; zero raises vector.
// R8: software places word buffers at even addresses.
// R9: software places memory_pointer at an even address.
// R10: delta writes current minus previous, then current becomes previous.
// R11: each delta write decrements counter; zero raises vector.
// R12: channel delta buffer is channel pointer minus twice counter minus 3.
// R13: pointer delta keeps memory_pointer; buffer is pointer minus twice counter plus 2.
// R14: software never loads zero counter for delta modes.
// R15: software seeds previous value with dummy data.
// R16: delta source pointer names only 16-bit registers.
// R17: status, return, enable, disable and break instructions defer service.
// R18: interrupt control register writes may defer service, per CPU state.
// R19: string and sum-of-products instructions are suspended for service, then resumed.
// R20: low six mode bits select the operation; delta codes fix top bits 10.
// R21: mode top bit chooses byte or word except for event counting.
// R22: after each service the request flag is cleared and execution resumes.
// R23: mode and channel pointer pairs are read from the fixed control word area.
// R24: delta subtraction is modulo 16 bits.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "mts_regs.svh"
module transfer_service #(
   parameter int NSRC = 16
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NSRC-1:0] irq_req,
   input wire logic instr_boundary,
   input wire logic hold_always,
   input wire logic hold_cond,
   input wire logic string_busy,
   output mts_pkg::mem_cmd_t mem_cmd,
   output logic mem_req,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   output logic [NSRC-1:0] req_clear,
   output logic [NSRC-1:0] vec_irq,
   output logic cpu_hold
);
   import mts_pkg::*;
   localparam int SW = $clog2(NSRC);

   state_t state_r, state_nxt;
   logic en_r;
   logic [15:0] src_en_r;
   logic [15:0] vec_count_r;
   logic [SW-1:0] src_r, pick;
   logic pend;
   logic [7:0] mode_r, ch_r, register_source_pointer_r, msc_r, cnt_nxt;
   logic [15:0] mptr_r, prev_r, data_r;
   logic zero_r;
   logic wait_r, start, done;
   logic [15:0] rdata, cw_addr, ch_addr, buf_addr, sfr_addr, prev_addr;
   mem_cmd_t cmd;
   logic [5:0] op;
   logic word, to_sfr, is_evt, is_dif, is_ptr, op_ok, go, cw_evt, cw_ok;

   // mode decode
   assign op = mode_r[5:0]; // R20
   assign is_evt = (op == `MODE_EVT);
   assign is_dif = (op == `MODE_DIF || op == `MODE_DIFP) && mode_r[7:6] == `DIF_TOP; // R20
   assign is_ptr = (op == `MODE_BLKP || op == `MODE_DIFP);
   assign op_ok = is_evt || is_dif || op == `MODE_BLK || op == `MODE_BLKP;
   assign word = is_dif || mode_r[`MODE_SIZE_BIT]; // R21 R16
   assign to_sfr = !is_dif && mode_r[`MODE_DIR_BIT]; // R3
   assign cw_addr = `CW_BASE + 16'({src_r, 1'b0}); // R23
   assign ch_addr = {`RAM_PAGE, ch_r};
   assign sfr_addr = {`SFR_PAGE, register_source_pointer_r};
   assign prev_addr = ch_addr - (is_ptr ? `OFS_PREV_P : `OFS_PREV);
   assign cnt_nxt = (is_evt && !mode_r[7]) ? msc_r + 8'h01 : msc_r - 8'h01; // R1 R5 R7 R11

   buffer_addr_calc u_addr (
      .op(op),
      .word(word),
      .ch_addr(ch_addr),
      .service_counter(msc_r),
      .mptr(mptr_r),
      .buf_addr(buf_addr)
   );

   mem_access_port u_port (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(start),
      .cmd(cmd),
      .mem_cmd(mem_cmd),
      .mem_req(mem_req),
      .mem_ack(mem_ack),
      .mem_rdata(mem_rdata),
      .done(done),
      .rdata(rdata)
   );

   // lowest index wins among enabled requests
   always_comb begin
      pend = 1'b0;
      pick = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         // a flag being cleared this cycle is still high; skip it
         if (irq_req[i] && src_en_r[i] && !req_clear[i]) begin // R22
            pend = 1'b1;
            pick = SW'(i);
         end
      end
   end

   // boundary after a deferring instruction is skipped; string ops yield
   assign go = en_r && pend && (string_busy || (instr_boundary && !hold_always && !hold_cond)); // R17 R18 R19

   always_comb begin
      cmd = '0;
      unique case (state_r)
         S_CW: cmd = '{we: 1'b0, word: 1'b1, addr: cw_addr, wdata: 16'h0000}; // R23
         S_REGISTER_SOURCE_POINTER: cmd = '{we: 1'b0, word: 1'b0, addr: ch_addr, wdata: 16'h0000}; // R2
         S_MSC: cmd = '{we: 1'b0, word: 1'b0, addr: ch_addr - `OFS_MSC, wdata: 16'h0000};
         S_MPTR: cmd = '{we: 1'b0, word: 1'b1, addr: ch_addr - `OFS_MPTR, wdata: 16'h0000};
         S_PREV: cmd = '{we: 1'b0, word: 1'b1, addr: prev_addr, wdata: 16'h0000};
         S_SRC: cmd = '{we: 1'b0, word: word, addr: (is_dif || !to_sfr) ? sfr_addr : buf_addr,
                        wdata: 16'h0000}; // R3
         S_DST: cmd = '{we: 1'b1, word: word, addr: to_sfr ? sfr_addr : buf_addr,
                        wdata: is_dif ? data_r - prev_r : data_r}; // R10 R24
         S_PREVW: cmd = '{we: 1'b1, word: 1'b1, addr: prev_addr, wdata: data_r}; // R10
         S_MPTRW: cmd = '{we: 1'b1, word: 1'b1, addr: ch_addr - `OFS_MPTR,
                          wdata: mptr_r + (word ? 16'h0002 : 16'h0001)}; // R6
         S_MSCW: cmd = '{we: 1'b1, word: 1'b0, addr: is_evt ? cw_addr + 16'h0001
                         : ch_addr - `OFS_MSC, wdata: {8'h00, cnt_nxt}};
         default: cmd = '0;
      endcase
   end

   assign start = state_r != S_IDLE && state_r != S_END && !wait_r;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         wait_r <= 1'b0;
      else if (start)
         wait_r <= 1'b1;
      else if (done)
         wait_r <= 1'b0;
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         S_IDLE: if (go) state_nxt = S_CW;
         S_CW: if (done) state_nxt = S_REGISTER_SOURCE_POINTER;
         S_REGISTER_SOURCE_POINTER: if (done) state_nxt = S_MSC;
         S_MSC: if (done) state_nxt = is_ptr ? S_MPTR : is_dif ? S_PREV : S_SRC;
         S_MPTR: if (done) state_nxt = is_dif ? S_PREV : S_SRC;
         S_PREV: if (done) state_nxt = S_SRC;
         S_SRC: if (done) state_nxt = S_DST;
         S_DST: if (done) state_nxt = is_dif ? S_PREVW : is_ptr ? S_MPTRW : S_MSCW; // R13
         S_PREVW: if (done) state_nxt = S_MSCW;
         S_MPTRW: if (done) state_nxt = S_MSCW;
         S_MSCW: if (done) state_nxt = S_END;
         S_END: state_nxt = S_IDLE;
         default: state_nxt = S_IDLE;
      endcase
      // event count and unknown codes skip the channel walk
      if (state_r == S_CW && done && (cw_evt || !cw_ok))
         state_nxt = cw_evt ? S_MSCW : S_END;
   end

   // is_evt/op_ok read mode_r; decode the fresh word for the S_CW branch
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         state_r <= S_IDLE;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         src_r <= '0;
         mode_r <= 8'h00;
         ch_r <= 8'h00;
      end else if (state_r == S_IDLE && go) begin
         src_r <= pick;
      end else if (state_r == S_CW && done) begin
         mode_r <= rdata[7:0];
         ch_r <= rdata[15:8];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         register_source_pointer_r <= 8'h00;
         msc_r <= 8'h00;
         mptr_r <= 16'h0000;
         prev_r <= 16'h0000;
         data_r <= 16'h0000;
      end else if (done) begin
         unique case (state_r)
            S_CW: msc_r <= rdata[15:8]; // R1
            S_REGISTER_SOURCE_POINTER: register_source_pointer_r <= rdata[7:0];
            S_MSC: msc_r <= rdata[7:0];
            S_MPTR: mptr_r <= rdata;
            S_PREV: prev_r <= rdata;
            S_SRC: data_r <= rdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         zero_r <= 1'b0;
      else if (state_r == S_CW)
         zero_r <= 1'b0;
      else if (state_r == S_MSCW && done)
         zero_r <= cnt_nxt == 8'h00; // R1 R5 R7 R11
   end

   // the fresh mode word must steer the S_CW exit
   assign cw_evt = rdata[5:0] == `MODE_EVT; // R20
   assign cw_ok = cw_evt || rdata[5:0] == `MODE_BLK || rdata[5:0] == `MODE_BLKP
      || ((rdata[5:0] == `MODE_DIF || rdata[5:0] == `MODE_DIFP) && rdata[7:6] == `DIF_TOP);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_clear <= '0;
         vec_irq <= '0;
         cpu_hold <= 1'b0;
      end else begin
         req_clear <= '0;
         vec_irq <= '0;
         if (state_r == S_IDLE && go)
            cpu_hold <= 1'b1; // R19
         if (state_r == S_END) begin
            cpu_hold <= 1'b0; // R22
            req_clear[src_r] <= 1'b1; // R22
            vec_irq[src_r] <= zero_r || !op_ok; // R5 R7 R11
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         vec_count_r <= 16'h0000;
      else if (state_r == S_END && (zero_r || !op_ok))
         vec_count_r <= vec_count_r + 16'h0001;
   end

   // apb slave, one wait state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && penable && !pready) begin
            unique case (paddr)
               `REG_CTRL: prdata <= {31'h0000_0000, en_r};
               `REG_SRC_EN: prdata <= {16'h0000, src_en_r};
               `REG_STATUS: prdata <= {20'h0_0000, 4'(src_r), state_r, 3'h0, cpu_hold};
               `REG_VEC_COUNT: prdata <= {16'h0000, vec_count_r};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_r <= `CTRL_RESET;
         src_en_r <= `SRC_EN_RESET;
      end else if (psel && penable && pready && pwrite) begin
         if (paddr == `REG_CTRL)
            en_r <= pwdata[`CTRL_EN_BIT];
         if (paddr == `REG_SRC_EN)
            src_en_r <= pwdata[15:0];
      end
   end

   property p_zero_vec;
      @(posedge ref_clk) disable iff (!rst_n)
      state_r == S_MSCW && done && cnt_nxt == 8'h00 |-> ##2 vec_irq[src_r];
   endproperty
   a_zero_vec: assert property (p_zero_vec) else $error("no vector at zero count"); // R5 R7 R11 R1

   property p_no_vec;
      @(posedge ref_clk) disable iff (!rst_n)
      state_r == S_MSCW && done && cnt_nxt != 8'h00 && op_ok |-> ##2 vec_irq == '0;
   endproperty
   a_no_vec: assert property (p_no_vec) else $error("vector before zero count"); // R1

   property p_end_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      state_r == S_END |=> req_clear[src_r] && !cpu_hold && state_r == S_IDLE;
   endproperty
   a_end_clear: assert property (p_end_clear) else $error("flag not cleared at end"); // R22

   property p_defer;
      @(posedge ref_clk) disable iff (!rst_n)
      state_r == S_IDLE && !string_busy && (hold_always || hold_cond) |=> state_r == S_IDLE;
   endproperty
   a_defer: assert property (p_defer) else $error("service after deferring instr"); // R17 R18

   property p_suspend;
      @(posedge ref_clk) disable iff (!rst_n)
      state_r == S_IDLE && en_r && pend && string_busy |=> cpu_hold && state_r == S_CW;
   endproperty
   a_suspend: assert property (p_suspend) else $error("string op not suspended"); // R19

   property p_register_source_pointer_fetch;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(mem_req) && state_r == S_REGISTER_SOURCE_POINTER |-> mem_cmd.addr == {`RAM_PAGE, ch_r} && !mem_cmd.we;
   endproperty
   a_register_source_pointer_fetch: assert property (p_register_source_pointer_fetch) else $error("source pointer not at channel"); // R2

   property p_blk_addr;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(mem_req) && state_r == S_DST && op == `MODE_BLK && !to_sfr |->
         mem_cmd.addr == ch_addr - (word ? 16'({msc_r, 1'b0}) : 16'(msc_r)) - 16'h0001;
   endproperty
   a_blk_addr: assert property (p_blk_addr) else $error("block buffer address wrong"); // R4

   property p_dif_addr;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(mem_req) && state_r == S_DST && is_dif |-> mem_cmd.word && mem_cmd.addr ==
         (is_ptr ? mptr_r + 16'h0002 : ch_addr - 16'h0003) - 16'({msc_r, 1'b0});
   endproperty
   a_dif_addr: assert property (p_dif_addr) else $error("delta buffer address wrong"); // R12 R13

   property p_dif_data;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(mem_req) && state_r == S_DST && is_dif |-> mem_cmd.wdata == 16'(data_r - prev_r);
   endproperty
   a_dif_data: assert property (p_dif_data) else $error("delta value wrong"); // R10 R24

   property p_mptr_step;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(mem_req) && state_r == S_MPTRW |-> mem_cmd.wdata - mptr_r == (word ? 16'h0002
         : 16'h0001);
   endproperty
   a_mptr_step: assert property (p_mptr_step) else $error("memory pointer step wrong"); // R6
endmodule // transfer_service

// >>> verif/mem_model.sv
`timescale 1ns/1ps
module mem_model (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] dly,
   input mts_pkg::mem_cmd_t mem_cmd,
   input wire logic mem_req,
   output logic mem_ack,
   output logic [15:0] mem_rdata
);
   import mts_pkg::*;
   logic [7:0] mem [0:65535];
   logic [3:0] wait_r;
   // answers after dly cycles; idle data toggles so stale reads show
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_ack <= 1'b0;
         wait_r <= 4'h0;
         mem_rdata <= 16'hA5A5;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end else if (mem_req && wait_r != dly) begin
         wait_r <= wait_r + 4'h1;
      end else if (mem_req) begin
         wait_r <= 4'h0;
         mem_ack <= 1'b1;
         mem_rdata <= {mem[mem_cmd.addr + 16'h0001], mem[mem_cmd.addr]};
         if (mem_cmd.we) begin
            mem[mem_cmd.addr] <= mem_cmd.wdata[7:0];
            if (mem_cmd.word) begin
               mem[mem_cmd.addr + 16'h0001] <= mem_cmd.wdata[15:8];
            end
         end
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule // mem_model

// >>> verif/interrupt_driven_transfer_service_bench.sv
`timescale 1ns/1ps
`include "mts_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module interrupt_driven_transfer_service_bench;
   import mts_pkg::*;
   logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, mem_req, mem_ack;
   logic instr_boundary, hold_always, hold_cond, string_busy, cpu_hold, rerr, w, dr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [15:0] irq_req, req_clear, vec_irq, mem_rdata, b, sv, bv, got, msk;
   logic [3:0] dly;
   mem_cmd_t mem_cmd;
   int fails, n_checks, exp_vecs, cc;

   transfer_service #(.NSRC(16)) u_transfer_service (.ref_clk(ref_clk), .rst_n(rst_n),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
      .instr_boundary(instr_boundary), .hold_always(hold_always), .hold_cond(hold_cond),
      .string_busy(string_busy), .mem_cmd(mem_cmd), .mem_req(mem_req), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .req_clear(req_clear), .vec_irq(vec_irq), .cpu_hold(cpu_hold));
   mem_model u_mem_model (.ref_clk(ref_clk), .rst_n(rst_n), .dly(dly), .mem_cmd(mem_cmd),
      .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task end_of_test;
      $display("checks %0d errors %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) begin
         fails++;
         end_of_test;
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0);
      `CHK("prdata", e, rdat)
      `CHK("pslverr", ee, rerr)
   endtask

   task pb(input logic [15:0] a, input logic [7:0] d);
      u_mem_model.mem[a] = d;
   endtask

   task put(input logic [15:0] a, input logic [15:0] d);
      u_mem_model.mem[a] = d[7:0];
      u_mem_model.mem[a + 16'h0001] = d[15:8];
   endtask

   function automatic logic [7:0] mb(input logic [15:0] a);
      return u_mem_model.mem[a];
   endfunction

   function automatic logic [15:0] mw(input logic [15:0] a);
      return {u_mem_model.mem[a + 16'h0001], u_mem_model.mem[a]};
   endfunction

   task cw(input int s, input logic [7:0] m, input logic [7:0] c);
      pb(`CW_BASE + 16'(2 * s), m);
      pb(`CW_BASE + 16'(2 * s + 1), c);
   endtask

   task svc(input int s, input logic ev);
      int i;
      @(posedge ref_clk);
      irq_req[s] <= 1'b1;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (req_clear[s] !== 1'b1 && i < 300);
      if (i >= 300) begin
         fails++;
         end_of_test;
      end
      irq_req[s] <= 1'b0;
      `CHK("req_clear", 16'h0001 << s, req_clear)
      `CHK("vec_irq", ev ? (16'h0001 << s) : 16'h0000, vec_irq)
      if (ev) exp_vecs++;
   endtask

   task quiet(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         `CHK("cpu_hold", 1'b0, cpu_hold)
      end
   endtask

   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, irq_req} = '0;
      {hold_always, hold_cond, string_busy, fails, n_checks, exp_vecs} = '0;
      instr_boundary = 1'b1;
      dly = 4'h0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd_chk(`REG_CTRL, 32'h0, 1'b0);
      rd_chk(`REG_SRC_EN, 32'h0, 1'b0);
      rd_chk(8'h10, 32'h0, 1'b1);
      apb(1'b1, `REG_CTRL, 32'h1);
      apb(1'b1, `REG_SRC_EN, 32'hFFFF);
      rd_chk(`REG_CTRL, 32'h1, 1'b0);
      // counter wraps up to zero
      cw(0, 8'h01, 8'hFF);
      svc(0, 1'b1);
      `CHK("event count", 8'h00, mb(16'hFE07))
      // held off, then taken during a string instruction
      cw(0, 8'h81, 8'h02);
      hold_always <= 1'b1;
      irq_req[0] <= 1'b1;
      quiet(10);
      hold_always <= 1'b0;
      hold_cond <= 1'b1;
      quiet(10);
      instr_boundary <= 1'b0;
      string_busy <= 1'b1;
      svc(0, 1'b0);
      `CHK("event count", 8'h01, mb(16'hFE07))
      hold_cond <= 1'b0;
      instr_boundary <= 1'b1;
      string_busy <= 1'b0;
      // channel block copy, all four size and direction codes
      for (cc = 0; cc < 4; cc++) begin
         w = cc[1];
         dr = cc[0];
         b = 16'hFE88 - (w ? 16'h0002 : 16'h0001) * 16'(cc + 1);
         sv = 16'h5AC3 ^ 16'(cc);
         bv = 16'hA53C ^ 16'(cc);
         msk = w ? 16'hFFFF : 16'h00FF;
         dly <= 4'(cc);
         cw(1, {cc[1:0], 6'h13}, 8'h89);
         pb(16'hFE89, 8'h20);
         put(b, bv);
         pb(16'hFE88, 8'(cc + 1));
         put(16'hFF20, sv);
         svc(1, cc == 0);
         got = dr ? mw(16'hFF20) : mw(b);
         `CHK("copy data", (dr ? bv : sv) & msk, got & msk)
         `CHK("copy counter", cc, mb(16'hFE88))
      end
      // pointer block copy, words
      cw(2, 8'h94, 8'hA1);
      pb(16'hFEA1, 8'h20);
      pb(16'hFEA0, 8'h02);
      put(16'hFE9E, 16'h1000);
      for (cc = 0; cc < 2; cc++) begin
         sv = 16'hBE00 + 16'(cc);
         put(16'hFF20, sv);
         svc(2, cc == 1);
         `CHK("ptr buffer", sv, mw(16'h1000 + 16'(2 * cc)))
         `CHK("mem pointer", 16'h1002 + 16'(2 * cc), mw(16'hFE9E))
         `CHK("ptr counter", 1 - cc, mb(16'hFEA0))
      end
      // channel delta across a capture wrap
      dly <= 4'h1;
      cw(3, 8'h99, 8'hC5);
      pb(16'hFEC5, 8'h30);
      pb(16'hFEC4, 8'h01);
      put(16'hFEC2, 16'hFFF0);
      put(16'hFF30, 16'h0010);
      svc(3, 1'b1);
      `CHK("delta", 16'h0020, mw(16'hFEC0))
      `CHK("previous", 16'h0010, mw(16'hFEC2))
      `CHK("delta counter", 8'h00, mb(16'hFEC4))
      // pointer delta, pointer kept
      cw(4, 8'h9A, 8'hE7);
      pb(16'hFEE7, 8'h30);
      pb(16'hFEE6, 8'h02);
      put(16'hFEE4, 16'h2000);
      put(16'hFEE2, 16'h1000);
      put(16'hFF30, 16'h1234);
      svc(4, 1'b0);
      `CHK("ptr delta", 16'h0234, mw(16'h1FFE))
      `CHK("kept pointer", 16'h2000, mw(16'hFEE4))
      `CHK("ptr previous", 16'h1234, mw(16'hFEE2))
      `CHK("ptr delta counter", 8'h01, mb(16'hFEE6))
      // unknown code: no transfer, flag cleared, vector raised
      cw(5, 8'h3F, 8'h00);
      svc(5, 1'b1);
      rd_chk(`REG_STATUS, 32'h0000_0500, 1'b0);
      rd_chk(`REG_VEC_COUNT, 32'(exp_vecs), 1'b0);
      end_of_test;
   end
endmodule // interrupt_driven_transfer_service_bench
